// *** verilog/tef_defines.svh ***
/*
 * Register offsets, reset values and fixed sizes of the tap event flag block.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef TEF_DEFINES_SVH
`define TEF_DEFINES_SVH

`define TEF_ADDR_W 8
`define TEF_DATA_W 8
`define TEF_AXES 3
`define TEF_OFS_TAP_CONFIG 8'h21
`define TEF_OFS_TAP_SOURCE 8'h22
`define TEF_OFS_TAP_LATENCY 8'h27
`define TEF_RST_TAP_CONFIG 8'h00
`define TEF_RST_TAP_SOURCE 8'h00
`define TEF_RST_TAP_LATENCY 8'h00
`define TEF_RDATA_UNMAPPED 8'h00
`define TEF_CNT_ZERO 8'h00
`define TEF_CNT_ONE 8'h01

`endif

// *** verilog/tef_pkg.sv ***
/*
 * Types shared by the tap event flag block: configuration and source layouts, sequencer states.
 * Assumes tef_defines.svh is on the include path.
 */
`include "tef_defines.svh"

package tef_pkg;

    // Configuration register layout, most significant bit first.
    typedef struct packed {
        logic double_tap_abort;
        logic flag_latch_on;
        logic z_double_tap_enable;
        logic z_single_tap_enable;
        logic y_double_tap_enable;
        logic y_single_tap_enable;
        logic x_double_tap_enable;
        logic x_single_tap_enable;
    } tef_cfg_t;

    // Source register layout, most significant bit first.
    typedef struct packed {
        logic tap_event_active;
        logic z_tap_hit;
        logic y_tap_hit;
        logic x_tap_hit;
        logic double_tap_flag;
        logic z_tap_sign;
        logic y_tap_sign;
        logic x_tap_sign;
    } tef_src_t;

    // Pulse qualifier inputs, one bit per axis, bit 0 is X.
    typedef struct packed {
        logic [`TEF_AXES-1:0] start;
        logic [`TEF_AXES-1:0] valid_end;
        logic [`TEF_AXES-1:0] negative;
    } tef_pulse_t;

    // Per-axis tap sequencer states.
    typedef enum logic [1:0] {
        TEF_IDLE,
        TEF_LATENCY,
        TEF_WINDOW
    } tef_seq_state_t;

endpackage : tef_pkg

// *** verilog/tef_tap_seq.sv ***
/*
 * One axis of tap sequencing: single tap on a valid pulse end, latency blanking, second-tap window.
 * Assumes pulse start/end qualifiers and the sample tick are synchronous one-cycle pulses on clk.
 */
`include "tef_defines.svh"

module tef_tap_seq (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic pulse_start,
    input wire logic pulse_end,
    input wire logic pulse_neg,
    input wire logic [`TEF_DATA_W-1:0] latency,
    input wire logic [`TEF_DATA_W-1:0] window,
    input wire logic abort_on,
    output logic single_evt,
    output logic double_evt,
    output logic evt_sign
);

    tef_pkg::tef_seq_state_t state_reg;
    logic [`TEF_DATA_W-1:0] cnt_reg;
    logic lat_pulse_reg;
    logic abort_reg;
    logic cnt_done;

    // A tick with the counter already at zero ends the current interval.
    assign cnt_done = tick && (cnt_reg == `TEF_CNT_ZERO);

    // Sequence state and interval counter.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= tef_pkg::TEF_IDLE;
            cnt_reg <= `TEF_CNT_ZERO;
        end else begin
            unique case (state_reg)
                tef_pkg::TEF_IDLE: begin
                    if (pulse_end) begin
                        state_reg <= tef_pkg::TEF_LATENCY;
                        cnt_reg <= latency;
                    end
                end
                tef_pkg::TEF_LATENCY: begin
                    // No pulse raises an event until the latency interval runs out; with abort on, one can still cancel the window.
                    if (cnt_done) begin
                        state_reg <= abort_reg ? tef_pkg::TEF_IDLE : tef_pkg::TEF_WINDOW;
                        cnt_reg <= window;
                    end else if (tick) begin
                        cnt_reg <= `TEF_DATA_W'(cnt_reg - `TEF_CNT_ONE);
                    end
                end
                tef_pkg::TEF_WINDOW: begin
                    if (pulse_end) begin
                        state_reg <= tef_pkg::TEF_LATENCY;
                        cnt_reg <= latency;
                    end else if (cnt_done) begin
                        state_reg <= tef_pkg::TEF_IDLE;
                    end else if (tick) begin
                        cnt_reg <= `TEF_DATA_W'(cnt_reg - `TEF_CNT_ONE);
                    end
                end
            endcase
        end
    end

    // Tracks a pulse that starts and ends inside latency; only with abort on does it cancel the double tap.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lat_pulse_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else if (state_reg != tef_pkg::TEF_LATENCY) begin
            lat_pulse_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            if (pulse_start) begin
                lat_pulse_reg <= 1'b1;
            end
            if (abort_on && lat_pulse_reg && pulse_end) begin
                abort_reg <= 1'b1;
            end
        end
    end

    // Event strobes; with abort off the latency pulse never blocks the window.
    assign single_evt = (state_reg == tef_pkg::TEF_IDLE) && pulse_end;
    assign double_evt = (state_reg == tef_pkg::TEF_WINDOW) && pulse_end;
    assign evt_sign = pulse_neg;

endmodule : tef_tap_seq

// *** verilog/tef_top.sv ***
/*
 * Tap event flag block: configuration, latency and source registers, per-axis sequencers,
 * source capture with optional latch, and the tap interrupt.
 * Assumes the serial protocol engine presents one-cycle register read and write strobes,
 * and that the pulse qualifiers and sample tick come from the threshold logic on CLK.
 */
`include "tef_defines.svh"

// Overview of operation
// - Abort off: latency pulse keeps double-tap detection
// - Abort on: latency-bounded pulse suspends double-tap
// - Latch on holds flags until source read
// - Per-axis double-tap enable, reset zero
// - Per-axis single-tap enable, reset zero
// - Flag shown only if axis and type enabled
// - Event-active set when any enabled event occurs
// - Separate hit bit per axis
// - Double-tap flag: one double, zero single
// - Per-axis sign: zero positive, one negative
// - Latched and active: status bits frozen
// - Source read clears all its status bits
// - Source read clears the tap interrupt
// - Pulses raise no event during programmable latency interval
module tef_top (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [`TEF_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [`TEF_DATA_W-1:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [`TEF_DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    input wire logic ODR_TICK,
    input wire logic [`TEF_AXES-1:0] TAP_START,
    input wire logic [`TEF_AXES-1:0] TAP_END,
    input wire logic [`TEF_AXES-1:0] TAP_NEG,
    input wire logic [`TEF_DATA_W-1:0] TAP_WINDOW,
    output logic TAP_INT
);

    tef_pkg::tef_cfg_t tap_config_reg;
    tef_pkg::tef_src_t tap_source_reg;
    tef_pkg::tef_src_t tap_source_next;
    tef_pkg::tef_pulse_t pulse_in;
    logic [`TEF_DATA_W-1:0] tap_latency_window_reg;
    logic [`TEF_DATA_W-1:0] rdata_next;
    logic [`TEF_AXES-1:0] single_evt;
    logic [`TEF_AXES-1:0] double_evt;
    logic [`TEF_AXES-1:0] evt_sign;
    logic [`TEF_AXES-1:0] single_ok;
    logic [`TEF_AXES-1:0] double_ok;
    logic [`TEF_AXES-1:0] axis_hit;
    logic [`TEF_AXES-1:0] axis_sign;
    logic any_event;
    logic source_read;
    logic frozen;

    // Picks the enable bit for one axis and event type from the configuration word.
    function automatic logic axis_enable(input tef_pkg::tef_cfg_t cfg, input int axis, input logic dbl);
        logic [5:0] bits;
        bits = {cfg.z_double_tap_enable, cfg.z_single_tap_enable,
                cfg.y_double_tap_enable, cfg.y_single_tap_enable,
                cfg.x_double_tap_enable, cfg.x_single_tap_enable};
        axis_enable = dbl ? bits[2 * axis + 1] : bits[2 * axis];
    endfunction : axis_enable

    // True when the bus addresses the given register.
    function automatic logic addr_hit(input logic [`TEF_ADDR_W-1:0] addr, input logic [`TEF_ADDR_W-1:0] ofs);
        addr_hit = (addr == ofs);
    endfunction : addr_hit

    // Gathers the per-axis pulse qualifiers into one carrier.
    assign pulse_in = '{start: TAP_START, valid_end: TAP_END, negative: TAP_NEG};

    // One sequencer per axis, each blanking its own latency interval.
    genvar gi;
    generate
        for (gi = 0; gi < `TEF_AXES; gi = gi + 1) begin : g_axis
            tef_tap_seq u_seq (
                .clk(CLK),
                .arst_n(ARST_N),
                .tick(ODR_TICK),
                .pulse_start(pulse_in.start[gi]),
                .pulse_end(pulse_in.valid_end[gi]),
                .pulse_neg(pulse_in.negative[gi]),
                .latency(tap_latency_window_reg),
                .window(TAP_WINDOW),
                .abort_on(tap_config_reg.double_tap_abort),
                .single_evt(single_evt[gi]),
                .double_evt(double_evt[gi]),
                .evt_sign(evt_sign[gi])
            );

            // An event counts only when both its axis and its type are enabled.
            assign single_ok[gi] = single_evt[gi] && axis_enable(tap_config_reg, gi, 1'b0);
            assign double_ok[gi] = double_evt[gi] && axis_enable(tap_config_reg, gi, 1'b1);
            assign axis_hit[gi] = single_ok[gi] || double_ok[gi];
            assign axis_sign[gi] = axis_hit[gi] && evt_sign[gi];
        end
    endgenerate

    // Source read strobe, and the freeze condition while latching holds an event.
    assign source_read = REG_RD && addr_hit(REG_ADDR, `TEF_OFS_TAP_SOURCE);
    assign any_event = |axis_hit;
    assign frozen = tap_config_reg.flag_latch_on && tap_source_reg.tap_event_active;

    // Next source value; a new event in the read cycle wins over the clear.
    always_comb begin
        tap_source_next = tap_source_reg;
        if (any_event && (!frozen || source_read)) begin
            tap_source_next.tap_event_active = 1'b1;
            tap_source_next.x_tap_hit = axis_hit[0];
            tap_source_next.y_tap_hit = axis_hit[1];
            tap_source_next.z_tap_hit = axis_hit[2];
            tap_source_next.double_tap_flag = |double_ok;
            tap_source_next.x_tap_sign = axis_sign[0];
            tap_source_next.y_tap_sign = axis_sign[1];
            tap_source_next.z_tap_sign = axis_sign[2];
        end else if (source_read) begin
            tap_source_next = tef_pkg::tef_src_t'(`TEF_RST_TAP_SOURCE);
        end
    end

    // Source register; shut to new events only while latching freezes it, and cleared by a source read that meets no new event.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_source_reg <= tef_pkg::tef_src_t'(`TEF_RST_TAP_SOURCE);
        end else begin
            tap_source_reg <= tap_source_next;
        end
    end

    // Configuration register writes.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_config_reg <= tef_pkg::tef_cfg_t'(`TEF_RST_TAP_CONFIG);
        end else if (REG_WR && addr_hit(REG_ADDR, `TEF_OFS_TAP_CONFIG)) begin
            tap_config_reg <= tef_pkg::tef_cfg_t'(REG_WDATA);
        end
    end

    // Latency register writes.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tap_latency_window_reg <= `TEF_RST_TAP_LATENCY;
        end else if (REG_WR && addr_hit(REG_ADDR, `TEF_OFS_TAP_LATENCY)) begin
            tap_latency_window_reg <= REG_WDATA;
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always_comb begin
        if (addr_hit(REG_ADDR, `TEF_OFS_TAP_CONFIG)) begin
            rdata_next = tap_config_reg;
        end else if (addr_hit(REG_ADDR, `TEF_OFS_TAP_SOURCE)) begin
            rdata_next = tap_source_reg;
        end else if (addr_hit(REG_ADDR, `TEF_OFS_TAP_LATENCY)) begin
            rdata_next = tap_latency_window_reg;
        end else begin
            rdata_next = `TEF_RDATA_UNMAPPED;
        end
    end

    // Read data returns the value seen before the read's own clear.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RDATA <= `TEF_RDATA_UNMAPPED;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            if (REG_RD) begin
                REG_RDATA <= rdata_next;
            end
        end
    end

    // Interrupt follows the event-active flag, so a source read drops it.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TAP_INT <= 1'b0;
        end else begin
            TAP_INT <= tap_source_next.tap_event_active;
        end
    end

endmodule : tef_top

// *** verification/tef_monitor.sv ***
/* Concurrent checks on the ports of tef_top.
   Assumes one clock and the active-low reset of tef_top. */
`include "tef_defines.svh"
module tef_monitor (
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [`TEF_ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [`TEF_DATA_W-1:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [`TEF_DATA_W-1:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic ODR_TICK,
    input wire logic [`TEF_AXES-1:0] TAP_START,
    input wire logic [`TEF_AXES-1:0] TAP_END,
    input wire logic [`TEF_AXES-1:0] TAP_NEG,
    input wire logic [`TEF_DATA_W-1:0] TAP_WINDOW,
    input wire logic TAP_INT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`TEF_DATA_W-1:0] cfg_reg;
    logic src_rd;
    // Marks a read of the source register.
    assign src_rd = REG_RD && REG_ADDR == `TEF_OFS_TAP_SOURCE;
    // Shadow of the configuration register.
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_reg <= `TEF_RST_TAP_CONFIG;
        end else if (REG_WR && REG_ADDR == `TEF_OFS_TAP_CONFIG) begin
            cfg_reg <= REG_WDATA;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_rd_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read got no valid strobe");
    a_rvalid_pulse: assert property (!REG_RD |=> !REG_RVALID)
        else $error("valid strobe without read");
    a_read_clears_int: assert property (src_rd && TAP_END == 3'h0 |=> !TAP_INT)
        else $error("source read left interrupt high");
    a_int_holds: assert property (TAP_INT && !src_rd |=> TAP_INT)
        else $error("interrupt dropped without read");
    a_no_event_quiet: assert property (!TAP_INT && TAP_END == 3'h0 |=> !TAP_INT)
        else $error("interrupt without tap");
    a_disabled_silent: assert property (cfg_reg[5:0] == 6'h00 && !TAP_INT |=> !TAP_INT)
        else $error("interrupt with all enables off");
    a_cfg_readback: assert property (REG_RD && !REG_WR && REG_ADDR == `TEF_OFS_TAP_CONFIG
        |=> REG_RDATA == $past(cfg_reg))
        else $error("configuration readback wrong");
    a_ea_in_read: assert property (src_rd |=> REG_RDATA[7] == $past(TAP_INT))
        else $error("active flag differs from interrupt");
    a_reread_empty: assert property (src_rd && TAP_END == 3'h0 ##1 src_rd |=> REG_RDATA == 8'h00)
        else $error("second source read not empty");
endmodule : tef_monitor

bind tef_top tef_monitor i_tef_monitor (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .ODR_TICK(ODR_TICK), .TAP_START(TAP_START), .TAP_END(TAP_END), .TAP_NEG(TAP_NEG),
    .TAP_WINDOW(TAP_WINDOW), .TAP_INT(TAP_INT));

// *** verification/tef_host.sv ***
/* Host model: single-byte register writes and reads.
   Assumes each task is entered just after a rising clock edge or later. */
module tef_host (
    input wire logic clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // Strobes idle low from time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    endtask : wr
    // One-cycle read; data counts only with the valid strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
    endtask : rd
    // Two back-to-back source reads.
    task automatic rd2(output logic [7:0] d1, output logic [7:0] d2);
        @(posedge clk);
        #1 reg_addr = 8'h22;
        reg_rd = 1'b1;
        @(posedge clk);
        #1 d1 = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d2 = reg_rvalid === 1'b1 ? reg_rdata : 8'hXX;
    endtask : rd2
endmodule : tef_host

// *** verification/tb_tef_top.sv ***
/* Self-checking bench for tef_top: defaults, enables, double taps, abort and latch.
   Assumes tef_host drives the register strobes. */
module tb_tef_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, ARST_N, ODR_TICK, TAP_INT, REG_WR, REG_RD, REG_RVALID;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, TAP_WINDOW, d1, d2;
    logic [2:0] TAP_START, TAP_END, TAP_NEG, m;
    int err_count, compares;
    tef_top i_tef_top (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .ODR_TICK(ODR_TICK),
        .TAP_START(TAP_START), .TAP_END(TAP_END), .TAP_NEG(TAP_NEG), .TAP_WINDOW(TAP_WINDOW), .TAP_INT(TAP_INT));
    tef_host i_tef_host (.clk(CLK), .reg_addr(REG_ADDR), .reg_wr(REG_WR), .reg_wdata(REG_WDATA),
        .reg_rd(REG_RD), .reg_rdata(REG_RDATA), .reg_rvalid(REG_RVALID));
    // Compares one value and counts it.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_tef_host.rd(a, d);
        chk("rdata", exp, d);
    endtask : rdchk
    // One pulse: start, then a valid end with its sign.
    task automatic tap(input logic [2:0] ax, input logic [2:0] ng);
        @(posedge CLK);
        #1 TAP_START = ax;
        @(posedge CLK);
        #1 TAP_START = 3'h0;
        TAP_END = ax;
        TAP_NEG = ng;
        @(posedge CLK);
        #1 TAP_END = 3'h0;
        TAP_NEG = 3'h0;
    endtask : tap
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge CLK);
            #1 ODR_TICK = 1'b1;
            @(posedge CLK);
            #1 ODR_TICK = 1'b0;
        end
    endtask : ticks
    task automatic t_defaults();
        rdchk(8'h21, 8'h00);
        rdchk(8'h22, 8'h00);
        rdchk(8'h27, 8'h00);
        rdchk(8'h30, 8'h00);
        tap(3'h7, 3'h7);
        chk("tap_int", 8'h00, {7'h00, TAP_INT});
        rdchk(8'h22, 8'h00);
        ticks(8);
        i_tef_host.wr(8'h22, 8'hFF);
        rdchk(8'h22, 8'h00);
    endtask : t_defaults
    task automatic t_enables();
        i_tef_host.wr(8'h21, 8'h01);
        tap(3'h2, 3'h2);
        chk("tap_int", 8'h00, {7'h00, TAP_INT});
        tap(3'h1, 3'h1);
        chk("tap_int", 8'h01, {7'h00, TAP_INT});
        i_tef_host.rd2(d1, d2);
        chk("rdata", 8'h91, d1);
        chk("rdata", 8'h00, d2);
        chk("tap_int", 8'h00, {7'h00, TAP_INT});
        ticks(8);
        i_tef_host.wr(8'h21, 8'h15);
        for (int a = 0; a < 3; a++) begin
            m = 3'h1 << a;
            tap(m, a[0] ? m : 3'h0);
            rdchk(8'h22, {1'b1, m, 1'b0, a[0] ? m : 3'h0});
            ticks(8);
        end
    endtask : t_enables
    // Second tap inside latency, then after it; abort decides the outcome.
    task automatic t_double(input logic [7:0] cfg, input logic [7:0] first, input logic [7:0] exp);
        i_tef_host.wr(8'h27, 8'h01);
        rdchk(8'h27, 8'h01);
        i_tef_host.wr(8'h21, cfg);
        tap(3'h1, 3'h0);
        rdchk(8'h22, first);
        tap(3'h1, 3'h0);
        rdchk(8'h22, 8'h00);
        ticks(2);
        tap(3'h1, 3'h0);
        rdchk(8'h22, exp);
        ticks(8);
    endtask : t_double
    task automatic t_latch(input logic [7:0] cfg, input logic [7:0] exp);
        i_tef_host.wr(8'h21, cfg);
        tap(3'h1, 3'h1);
        ticks(8);
        tap(3'h2, 3'h0);
        rdchk(8'h22, exp);
        rdchk(8'h22, 8'h00);
        ticks(8);
    endtask : t_latch
    // Reset in mid-run drops a pending event and returns every register to zero.
    task automatic t_reset();
        i_tef_host.wr(8'h21, 8'h01);
        tap(3'h1, 3'h0);
        chk("tap_int", 8'h01, {7'h00, TAP_INT});
        @(posedge CLK);
        #1 ARST_N = 1'b0;
        @(posedge CLK);
        #1 ARST_N = 1'b1;
        chk("tap_int", 8'h00, {7'h00, TAP_INT});
        rdchk(8'h21, 8'h00);
        rdchk(8'h27, 8'h00);
        rdchk(8'h22, 8'h00);
    endtask : t_reset
    task automatic give_verdict();
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    // Free-running 100 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // Watchdog far beyond the expected run length.
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
    // Reset, then the scenarios in turn.
    initial begin
        ARST_N = 1'b0;
        ODR_TICK = 1'b0;
        TAP_START = 3'h0;
        TAP_END = 3'h0;
        TAP_NEG = 3'h0;
        TAP_WINDOW = 8'h03;
        err_count = 0;
        compares = 0;
        repeat (20) @(posedge CLK);
        #1 ARST_N = 1'b1;
        t_defaults();
        t_enables();
        t_double(8'h03, 8'h90, 8'h98);
        t_double(8'h83, 8'h90, 8'h90);
        t_double(8'h02, 8'h00, 8'h98);
        t_latch(8'h55, 8'h91);
        t_latch(8'h15, 8'hA0);
        t_reset();
        give_verdict();
    end
endmodule : tb_tef_top
